// [bench/lamp_burst_dimming_control_tb.sv]
// Purpose: self-checking bench for the burst dimming core
// Assumes: dividers shortened to 20 and 2560
// Notes:   peer model sources the burst on the sync pin; the lamp pin loops back the core's own clock
`timescale 1ns/1ps
module lamp_burst_dimming_control_tb;
  localparam int LDIV = 20;
  typedef struct {
    int sel;
    int lim;
  } note_t;
  logic                             clk_sys_i;
  logic                             reset_i;
  lamp_burst_pkg::cfg_t             cfg;
  logic [31:0]                      stg;
  logic [7:0]                       bright;
  logic [3:0]                       struck;
  logic                             go;
  logic [15:0]                      hlen;
  logic                             peer_burst;
  logic                             peer_lamp;
  logic                             bso;
  logic                             bsoe;
  logic                             lso;
  logic                             lsoe;
  logic                             pwm;
  logic                             dosc = 1'b0;
  lamp_burst_pkg::gate_pair_t [3:0] gates;
  note_t                            sq[$];
  note_t                            lq[$];
  int failures = 0;
  int checks = 0;
  int seed = 50;
  int cyc = 0;
  peer_sync_model #(.HALF(LDIV / 2)) u_peer_sync_model (
    .clk_sys_i(clk_sys_i), .go_i(go), .high_len_i(hlen),
    .burst_o(peer_burst), .lamp_o(peer_lamp));
  lamp_burst_dimming_control #(.LAMP_DIV(LDIV), .DIM_DIV(2560))
    u_lamp_burst_dimming_control (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .cfg_i(cfg),
    .stagger_delay_regs_i(stg), .bright_code_i(bright),
    .lamp_struck_i(struck), .burst_sync_pin_i(bsoe ? peer_burst : bso),
    .burst_sync_pin_o(bso), .burst_sync_pin_oe_n_o(bsoe),
    .lamp_sync_pin_i(lsoe ? peer_lamp : lso), .lamp_sync_pin_o(lso),
    .lamp_sync_pin_oe_n_o(lsoe), .dim_osc_pin_i(dosc),
    .gates_o(gates), .burst_pwm_o(pwm));
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task automatic cmp(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("ERROR %0t got %0d want %0d..%0d", $time, got, lo, hi);
    end
  endtask : cmp
  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic burst(input int ch, input int s, input int hl, input int lo);
    stg[8*ch +: 8] <= s[7:0];
    sq.push_back('{ch, lo});
    repeat (4) @(posedge clk_sys_i);
    go <= 1'b1;
    hlen <= hl[15:0];
    @(posedge clk_sys_i);
    go <= 1'b0;
    repeat (hl + 300) @(posedge clk_sys_i);
  endtask : burst
  task automatic lamp(input int code, input int st, input int lo, input int hi);
    cfg.strike_boost_code <= code[2:0];
    struck <= st[3:0];
    repeat (3 * LDIV) @(posedge clk_sys_i);
    lq.push_back('{lo, hi});
    repeat (3 * LDIV) @(posedge clk_sys_i);
  endtask : lamp
  // first gate delay per burst; -1 when the burst ends first
  initial begin : watch_stagger
    note_t n;
    int d;
    forever begin
      @(posedge pwm);
      if (sq.size() > 0) begin
        n = sq.pop_front();
        d = 0;
        while (pwm === 1'b1 && gates[n.sel] === 2'b00) begin
          @(posedge clk_sys_i);
          d++;
        end
        if (pwm !== 1'b1) d = -1;
        if (n.lim < 0) cmp(d, -1, -1);
        else cmp(d, n.lim, n.lim + 3 * LDIV);
      end
    end
  end
  initial begin : watch_lamp
    note_t n;
    realtime t0;
    forever begin
      @(posedge lso);
      if (lq.size() > 0) begin
        t0 = $realtime;
        @(posedge lso);
        n = lq.pop_front();
        cmp(int'(($realtime - t0) / 100.0), n.sel, n.lim);
      end
    end
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    // external dim clock, period 1024 cycles, ignored by receivers
    dosc <= cyc[9];
    if (cyc == 80000) begin
      failures++;
      close_out();
    end
  end
  initial begin : drive
    int s;
    int hi;
    reset_i = 1'b1;
    cfg = '0;
    cfg.burst_source_select = 1'b1;
    stg = 32'h0000_0000;
    bright = 8'h00;
    struck = 4'hF;
    go = 1'b0;
    hlen = 16'h0000;
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      cfg.control_reg_two[2:1] <= r[1:0];
      for (int ch = 0; ch < 4; ch++) begin
        s = $random(seed) & 7;
        burst(ch, s, 1500, s * (8 >> r) * LDIV);
      end
    end
    burst(2, 200, 400, -1);
    $display("test stagger done");
    lamp(0, 0, LDIV, LDIV);
    lamp(7, 0, LDIV / 2, LDIV / 2);
    lamp(3, 0, LDIV / 2 + 1, LDIV - 1);
    lamp(7, 15, LDIV, LDIV);
    $display("test strike boost done");
    cfg.burst_source_select <= 1'b0;
    cfg.control_reg_two[7] <= 1'b1;
    bright <= 8'hFF;
    for (int sl = 0; sl < 2; sl++) begin
      cfg.control_reg_three[0] <= sl[0];
      cfg.burst_out_gate <= sl[0];
      cfg.dim_clock_source_select <= sl[0];
      repeat (3000) @(posedge clk_sys_i);
      hi = 0;
      repeat (6000) begin
        @(posedge clk_sys_i);
        hi += int'(pwm === 1'b1);
      end
      s = 6000 * int'(lamp_burst_pkg::DUTY_MIN) / 256;
      cmp(hi, sl ? s - 100 : 6000, sl ? s + 100 : 6000);
    end
    $display("test internal duty done");
    close_out();
  end
endmodule : lamp_burst_dimming_control_tb

// [bench/lamp_burst_sva.sv]
// Purpose: port checks for the burst dimming core
// Assumes: one clock domain, reset_i active high
// Notes:   bound to every instance of the core
`timescale 1ns/1ps
module lamp_burst_sva #(
  parameter int unsigned LAMP_DIV = 20
) (
  input wire logic                             clk_sys_i,
  input wire logic                             reset_i,
  input wire lamp_burst_pkg::cfg_t             cfg_i,
  input wire logic                             burst_sync_pin_i,
  input wire logic                             burst_sync_pin_o,
  input wire logic                             burst_sync_pin_oe_n_o,
  input wire logic                             lamp_sync_pin_o,
  input wire logic                             lamp_sync_pin_oe_n_o,
  input wire lamp_burst_pkg::gate_pair_t [3:0] gates_o,
  input wire logic                             burst_pwm_o
);
  logic [3:0]  ga;
  logic [3:0]  gb;
  logic [3:0]  ga_reg;
  logic [7:0]  up_reg;
  logic        lamp_reg;
  int unsigned run_reg;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ga[i] = gates_o[i].gate_a;
      gb[i] = gates_o[i].gate_b;
    end
  end
  // run_reg: cycles since the lamp clock last changed
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ga_reg <= 4'h0;
      up_reg <= 8'h00;
      lamp_reg <= 1'b0;
      run_reg <= 0;
    end else begin
      ga_reg <= ga;
      lamp_reg <= lamp_sync_pin_o;
      if (up_reg != 8'h08) up_reg <= up_reg + 8'h01;
      run_reg <= (lamp_sync_pin_o != lamp_reg) ? 0 : run_reg + 1;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  property p_gates_quiet;
    !burst_pwm_o && !$past(burst_pwm_o) |-> gates_o == '0;
  endproperty
  property p_no_overlap; (ga & gb) == 4'h0; endproperty
  property p_phase_apart; $onehot0(ga & ~ga_reg); endproperty
  property p_burst_rx;
    cfg_i.burst_source_select [*4] ##0 up_reg == 8'h08
      |-> burst_pwm_o == $past(burst_sync_pin_i, 3);
  endproperty
  property p_burst_dir;
    burst_sync_pin_oe_n_o ==
      (cfg_i.burst_source_select | cfg_i.burst_out_gate);
  endproperty
  property p_burst_echo;
    !burst_sync_pin_oe_n_o |-> burst_sync_pin_o == burst_pwm_o;
  endproperty
  property p_lamp_dir;
    lamp_sync_pin_oe_n_o == cfg_i.lamp_clock_source_select;
  endproperty
  property p_lamp_live; run_reg < LAMP_DIV; endproperty
  a_gates_quiet: assert property (p_gates_quiet)
    else $error("gates active while burst low");
  a_no_overlap: assert property (p_no_overlap)
    else $error("both gates of a channel high");
  a_phase_apart: assert property (p_phase_apart)
    else $error("two channels turned on together");
  a_burst_rx: assert property (p_burst_rx)
    else $error("burst does not follow sync pin");
  a_burst_dir: assert property (p_burst_dir)
    else $error("burst pin direction wrong");
  a_burst_echo: assert property (p_burst_echo)
    else $error("burst pin differs from burst");
  a_lamp_dir: assert property (p_lamp_dir)
    else $error("lamp pin direction wrong");
  a_lamp_live: assert property (p_lamp_live)
    else $error("lamp clock stalled");
  c_rx: cover property (cfg_i.burst_source_select && $rose(burst_pwm_o));
  c_tx: cover property (!burst_sync_pin_oe_n_o && $rose(burst_pwm_o));
  c_gate: cover property (ga != 4'h0);
endmodule : lamp_burst_sva
bind lamp_burst_dimming_control lamp_burst_sva #(.LAMP_DIV(LAMP_DIV)) u_sva (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .cfg_i(cfg_i),
  .burst_sync_pin_i(burst_sync_pin_i), .burst_sync_pin_o(burst_sync_pin_o),
  .burst_sync_pin_oe_n_o(burst_sync_pin_oe_n_o),
  .lamp_sync_pin_o(lamp_sync_pin_o),
  .lamp_sync_pin_oe_n_o(lamp_sync_pin_oe_n_o),
  .gates_o(gates_o), .burst_pwm_o(burst_pwm_o));

// [bench/peer_sync_model.sv]
// Purpose: peer controller acting as burst and lamp clock source
// Assumes: bench asks for one burst at a time, length in clocks
// Notes:   a source peer drives both sync lines at all times
`timescale 1ns/1ps
module peer_sync_model #(
  parameter int HALF = 10
) (
  input  wire logic        clk_sys_i,
  input  wire logic        go_i,
  input  wire logic [15:0] high_len_i,
  output logic             burst_o,
  output logic             lamp_o
);
  int hcnt = 0;
  int lcnt = 0;
  initial burst_o = 1'b0;
  initial lamp_o = 1'b0;
  // lamp clock free running, never paused
  always @(posedge clk_sys_i) begin
    lcnt <= (lcnt == HALF - 1) ? 0 : lcnt + 1;
    if (lcnt == HALF - 1) lamp_o <= ~lamp_o;
    if (go_i && !burst_o) begin
      burst_o <= 1'b1;
      hcnt <= int'(high_len_i);
    end else if (burst_o) begin
      hcnt <= hcnt - 1;
      if (hcnt <= 1) burst_o <= 1'b0;
    end
  end
endmodule : peer_sync_model

// [verilog/lamp_burst_dimming_control.sv]
// Purpose: four-channel burst dimming and lamp clock core
// Assumes: control bits come in already loaded from nonvolatile storage
// Notes:   sync pins are split into in, out and active-low output enable
`timescale 1ns/1ps
module lamp_burst_dimming_control #(
  parameter int unsigned LAMP_DIV = lamp_burst_pkg::LAMP_DIV_NOM,
  parameter int unsigned DIM_DIV  = lamp_burst_pkg::DIM_DIV_NOM
) (
  // clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  reset_i,
  // configuration
  input  wire lamp_burst_pkg::cfg_t  cfg_i,
  input  wire logic [31:0]           stagger_delay_regs_i,
  input  wire logic [7:0]            bright_code_i,
  input  wire logic [3:0]            lamp_struck_i,
  // sync pins
  input  wire logic                  burst_sync_pin_i,
  output logic                       burst_sync_pin_o,
  output logic                       burst_sync_pin_oe_n_o,
  input  wire logic                  lamp_sync_pin_i,
  output logic                       lamp_sync_pin_o,
  output logic                       lamp_sync_pin_oe_n_o,
  input  wire logic                  dim_osc_pin_i,
  // gate drive
  output lamp_burst_pkg::gate_pair_t [3:0] gates_o,
  output logic                       burst_pwm_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  bsync_s;
    logic [1:0]  lamp_sync_pin_s;
    logic [1:0]  dosc_s;
    logic        lamp_sync_pin_d;
    logic        dosc_d;
    logic [15:0] lamp_cnt;
    logic        lamp_clk;
    logic [15:0] phase_cnt;
    logic [15:0] half_len;
    logic [15:0] meas_cnt;
    logic [23:0] dim_cnt;
    logic [23:0] dim_per;
    logic [15:0] dim_step;
    logic [7:0]  step_cnt;
    logic        burst;
    logic        burst_d;
  } core_state_t;

  core_state_t st_reg;
  core_state_t st_next;
  logic [3:0]  mult;
  logic [7:0]  duty;
  logic [15:0] lamp_div_eff;
  logic        lamp_tick;
  logic        dim_tick;
  logic        any_strike;
  logic [3:0]  phase_tick;
  logic [7:0]  lvl_lo;
  logic [7:0]  lvl_hi;
  logic [7:0]  b_eff;
  logic [15:0] span_prod;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  always_comb begin
    unique case ({cfg_i.control_reg_two[lamp_burst_pkg::CR2_DIM_HI],
                  cfg_i.control_reg_two[lamp_burst_pkg::CR2_DIM_LO]})
      2'b00:   mult = 4'h8;
      2'b01:   mult = 4'h4;
      2'b10:   mult = 4'h2;
      default: mult = 4'h1;
    endcase
  end

  // brightness mapping; slope inverts the code, range picks limits
  always_comb begin
    if (cfg_i.control_reg_two[lamp_burst_pkg::CR2_BRIGHT_RANGE]) begin
      lvl_lo = lamp_burst_pkg::LVL_0V0;
      lvl_hi = lamp_burst_pkg::LVL_3V3;
    end else begin
      lvl_lo = lamp_burst_pkg::LVL_0V5;
      lvl_hi = lamp_burst_pkg::LVL_2V0;
    end
    // negative slope mirrors the code inside the range, clamped below
    b_eff = bright_code_i;
    if (cfg_i.control_reg_three[lamp_burst_pkg::CR3_SLOPE])
      b_eff = (bright_code_i > 8'(lvl_lo + lvl_hi)) ? 8'h00 :
              8'(lvl_lo + lvl_hi - bright_code_i);
    span_prod = 16'h0000;
    if (b_eff <= lvl_lo) begin
      duty = lamp_burst_pkg::DUTY_MIN;
    end else if (b_eff >= lvl_hi) begin
      duty = lamp_burst_pkg::DUTY_FULL;
    end else begin
      span_prod = 16'(b_eff - lvl_lo) *
                  16'(lamp_burst_pkg::DUTY_FULL - lamp_burst_pkg::DUTY_MIN);
      duty = 8'(16'(lamp_burst_pkg::DUTY_MIN) +
                span_prod / 16'(lvl_hi - lvl_lo));
    end
  end

  // strike boost shortens the lamp period: code 7 halves it
  assign any_strike = |(~lamp_struck_i);
  always_comb begin
    if (any_strike)
      lamp_div_eff = 16'((LAMP_DIV * 14) /
                         (14 + 2 * 32'(cfg_i.strike_boost_code)));
    else
      lamp_div_eff = 16'(LAMP_DIV);
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next         = st_reg;
    st_next.bsync_s = {st_reg.bsync_s[0], burst_sync_pin_i};
    st_next.lamp_sync_pin_s = {st_reg.lamp_sync_pin_s[0], lamp_sync_pin_i};
    st_next.dosc_s  = {st_reg.dosc_s[0], dim_osc_pin_i};
    st_next.lamp_sync_pin_d = st_reg.lamp_sync_pin_s[1];
    st_next.dosc_d  = st_reg.dosc_s[1];
    lamp_tick       = 1'b0;
    dim_tick        = 1'b0;

    // lamp clock: internal divider or edges of the sync pin
    if (!cfg_i.lamp_clock_source_select) begin
      // low half first, so reset never stretches the first period
      if (st_reg.lamp_cnt >= lamp_div_eff - 16'h0001) begin
        st_next.lamp_cnt = 16'h0000;
        st_next.lamp_clk = 1'b0;
      end else begin
        st_next.lamp_cnt = st_reg.lamp_cnt + 16'h0001;
        if (st_reg.lamp_cnt == (lamp_div_eff >> 1)) begin
          st_next.lamp_clk = 1'b1;
          lamp_tick        = 1'b1;
        end
      end
    end else begin
      lamp_tick        = st_reg.lamp_sync_pin_s[1] && !st_reg.lamp_sync_pin_d;
      st_next.lamp_clk = st_reg.lamp_sync_pin_s[1];
    end

    // measure lamp period so the phase offsets follow any source
    if (lamp_tick) begin
      st_next.half_len  = st_reg.meas_cnt >> 1;
      st_next.meas_cnt  = 16'h0000;
      st_next.phase_cnt = 16'h0000;
    end else begin
      if (st_reg.meas_cnt != 16'hFFFF)
        st_next.meas_cnt = st_reg.meas_cnt + 16'h0001;
      st_next.phase_cnt = st_reg.phase_cnt + 16'h0001;
    end

    // dim clock: pin edges or internal divider, 256 sub-steps per edge
    if (cfg_i.dim_clock_source_select) begin
      // step length follows the pin period measured one cycle earlier
      if (st_reg.dim_per != 24'hFFFFFF)
        st_next.dim_per = st_reg.dim_per + 24'h000001;
      if (st_reg.dosc_s[1] && !st_reg.dosc_d) begin
        st_next.dim_per  = 24'h000000;
        st_next.dim_step = 16'(st_reg.dim_per >> 8);
      end
      if (st_reg.dim_cnt >= 24'(st_reg.dim_step)) begin
        st_next.dim_cnt = 24'h000000;
        dim_tick        = 1'b1;
      end else begin
        st_next.dim_cnt = st_reg.dim_cnt + 24'h000001;
      end
    end else begin
      if (st_reg.dim_cnt >= 24'((DIM_DIV * 32'(mult)) >> 11)) begin
        st_next.dim_cnt = 24'h000000;
        dim_tick        = 1'b1;
      end else begin
        st_next.dim_cnt = st_reg.dim_cnt + 24'h000001;
      end
    end

    // burst waveform
    if (dim_tick)
      st_next.step_cnt = st_reg.step_cnt + 8'h01;
    if (cfg_i.burst_source_select) begin
      st_next.burst = st_reg.bsync_s[1];
    end else begin
      st_next.burst = (duty == lamp_burst_pkg::DUTY_FULL) ||
                      (st_next.step_cnt < duty);
    end
    st_next.burst_d = st_reg.burst;
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------
  // the burst itself is shared; only each gate phase is offset
  genvar ch;
  generate
    for (ch = 0; ch < lamp_burst_pkg::CHANNELS; ch++) begin : g_ch
      assign phase_tick[ch] = (st_reg.phase_cnt ==
                               16'((32'(st_reg.half_len) * 2 * ch) /
                                   lamp_burst_pkg::CHANNELS));
      lamp_channel_gate u_gate (
        .clk_sys_i    (clk_sys_i),
        .reset_i      (reset_i),
        .phase_tick_i (phase_tick[ch]),
        .burst_i      (st_reg.burst),
        .burst_rise_i (st_reg.burst && !st_reg.burst_d),
        .step_mult_i  (mult),
        .stagger_i    (stagger_delay_regs_i[ch*8 +: 8]),
        .half_len_i   (st_reg.half_len),
        .gate_a_o     (gates_o[ch].gate_a),
        .gate_b_o     (gates_o[ch].gate_b)
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  assign burst_pwm_o           = st_reg.burst;
  assign burst_sync_pin_o      = st_reg.burst;
  assign burst_sync_pin_oe_n_o = cfg_i.burst_source_select ||
                                 cfg_i.burst_out_gate;
  assign lamp_sync_pin_o       = st_reg.lamp_clk;
  assign lamp_sync_pin_oe_n_o  = cfg_i.lamp_clock_source_select;

endmodule : lamp_burst_dimming_control

// [verilog/lamp_burst_pkg.sv]
// Purpose: constants and carrier types for the lamp burst dimming core
// Assumes: 10 MHz system clock; oscillators modelled as clk_sys_i dividers
// Notes:   shared by the core and its per-channel gate module
// Behaviour
// - four channel gate phases spaced evenly
// - phasing shifts gates, never the burst waveform
// - burst high drives gates alternately at lamp rate
// - burst low holds all gates inactive
// - dim clock from pin or internal oscillator
// - dim range bits decode factor 8/4/2/1
// - duty minimum below, full above, linear between
// - receiver ignores brightness and dim oscillator
// - each channel has own 8-bit stagger
// - stagger equals value times M lamp periods
// - stagger beyond burst high gives no gates
// - strike code boosts lamp frequency up to double
// - lamp frequency returns to nominal only once all four lamps are struck
// - sixteen lamp cycle soft-start every burst
package lamp_burst_pkg;

  localparam int unsigned CHANNELS        = 4;
  localparam int unsigned CLK_HZ          = 10_000_000;
  // nominal internal lamp clock, dim clock and brightness code width
  localparam int unsigned LAMP_HZ_NOM     = 50_000;
  localparam int unsigned DIM_HZ_NOM      = 160;
  localparam int unsigned LAMP_DIV_NOM    = CLK_HZ / LAMP_HZ_NOM;
  localparam int unsigned DIM_DIV_NOM     = CLK_HZ / DIM_HZ_NOM;
  localparam int unsigned BRIGHT_W        = 8;
  localparam int unsigned SOFT_CYCLES     = 16;
  localparam int unsigned STRIKE_MAX_CODE = 7;
  // burst waveform counts 256 dim-clock-derived steps per burst cycle
  localparam int unsigned STEP_W          = 8;
  // brightness levels, as codes of the 0..3.3 V converter input
  localparam logic [7:0] LVL_0V0          = 8'h00;
  localparam logic [7:0] LVL_0V5          = 8'h27;
  localparam logic [7:0] LVL_2V0          = 8'h9B;
  localparam logic [7:0] LVL_3V3          = 8'hFF;
  localparam logic [7:0] DUTY_MIN         = 8'h19;
  localparam logic [7:0] DUTY_FULL        = 8'hFF;
  // control register bit positions
  localparam int unsigned CR2_BRIGHT_RANGE = 7;
  localparam int unsigned CR2_DIM_HI       = 2;
  localparam int unsigned CR2_DIM_LO       = 1;
  localparam int unsigned CR3_SLOPE        = 0;

  typedef struct packed {
    logic       burst_source_select;
    logic       dim_clock_source_select;
    logic       burst_out_gate;
    logic       lamp_clock_source_select;
    logic       lamp_range_select;
    logic [2:0] strike_boost_code;
    logic [7:0] control_reg_two;
    logic [7:0] control_reg_three;
  } cfg_t;

  typedef struct packed {
    logic gate_a;
    logic gate_b;
  } gate_pair_t;

endpackage : lamp_burst_pkg

// [verilog/lamp_channel_gate.sv]
// Purpose: one channel: stagger, soft-start and alternating gate drive
// Assumes: phase_tick_i pulses once per lamp period, all on clk_sys_i
// Notes:   phase of the channel chosen by the caller through phase_tick_i
`timescale 1ns/1ps
module lamp_channel_gate (
  // clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     reset_i,
  // timing
  input  wire logic                     phase_tick_i,
  input  wire logic                     burst_i,
  input  wire logic                     burst_rise_i,
  input  wire logic [3:0]               step_mult_i,
  input  wire logic [7:0]               stagger_i,
  input  wire logic [15:0]              half_len_i,
  // drive
  output logic                          gate_a_o,
  output logic                          gate_b_o
);

  typedef struct packed {
    logic [11:0] wait_cnt;
    logic        waiting;
    logic        active;
    logic        side;
    logic [4:0]  soft_cnt;
    logic [15:0] on_cnt;
    logic        gate_a;
    logic        gate_b;
  } chan_state_t;

  chan_state_t st_reg;
  chan_state_t st_next;
  logic [15:0] on_len;

  always_comb begin
    st_next = st_reg;
    // soft-start: on time grows in sixteenths, rounded up so the first
    // lamp cycle of a burst already carries a short pulse
    on_len = (st_reg.soft_cnt >= 5'(lamp_burst_pkg::SOFT_CYCLES)) ?
             half_len_i :
             16'(((32'(half_len_i) *
                   (32'(st_reg.soft_cnt) + 32'h0000_0001)) +
                  32'h0000_000F) >> 4);
    if (burst_rise_i) begin
      st_next.wait_cnt = 12'(stagger_i) * 12'(step_mult_i);
      st_next.waiting  = 1'b1;
      st_next.active   = 1'b0;
      st_next.soft_cnt = 5'h00;
    end else if (phase_tick_i && st_reg.waiting) begin
      if (st_reg.wait_cnt == 12'h000) begin
        st_next.waiting = 1'b0;
        st_next.active  = 1'b1;
        // every burst opens on gate_a with a fresh on-time count
        st_next.side    = 1'b0;
        st_next.on_cnt  = 16'h0000;
      end else begin
        st_next.wait_cnt = st_reg.wait_cnt - 12'h001;
      end
    end else if (phase_tick_i && st_reg.active) begin
      st_next.side   = ~st_reg.side;
      st_next.on_cnt = 16'h0000;
      if (st_reg.side && st_reg.soft_cnt < 5'(lamp_burst_pkg::SOFT_CYCLES))
        st_next.soft_cnt = st_reg.soft_cnt + 5'h01;
    end else if (st_reg.on_cnt != 16'hFFFF) begin
      st_next.on_cnt = st_reg.on_cnt + 16'h0001;
    end
    // burst fall ends everything, also a stagger still waiting
    if (!burst_i) begin
      st_next.waiting = 1'b0;
      st_next.active  = 1'b0;
    end
    st_next.gate_a = st_next.active && !st_next.side &&
                     (st_next.on_cnt < on_len) && burst_i;
    st_next.gate_b = st_next.active && st_next.side &&
                     (st_next.on_cnt < on_len) && burst_i;
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign gate_a_o = st_reg.gate_a;
  assign gate_b_o = st_reg.gate_b;

endmodule : lamp_channel_gate
